// >>> design/ecsr_pkg.sv
// package of constants, states and carriers for the memory-side host controller
package ecsr_pkg;

  // array organisation
  localparam int ADDR_W = 16;                    // word address width
  localparam int DATA_W = 16;                    // word width, two byte lanes
  localparam int LANES  = 2;                     // byte lanes
  localparam int CNT_W  = 4;                     // phase timer width

  // clock and documented times, in ns
  localparam int CLK_NS         = 5;             // 200 MHz system clock
  localparam int T_RC_NS        = 45;            // read_cycle_period, least
  localparam int T_AA_NS        = 45;            // addr_to_data_delay, most
  localparam int T_WP_NS        = 35;            // write pulse width, least
  localparam int T_OHZ_NS       = 15;            // output disable to high-z, most
  localparam int T_WHZ_NS       = 15;            // write to output high-z, most

  // cycle counts; every host wait rounds up so the device figure is met
  localparam int RC_CYC   = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int AA_CYC   = (T_AA_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TURN_CYC = (((T_OHZ_NS > T_WHZ_NS) ? T_OHZ_NS : T_WHZ_NS)
                             + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = 1;                   // data hold and write recovery
  localparam int REST_CYC = 1;                   // deselect gap between accesses

  // controller states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RD_WAIT = 3'b001,
    ST_WR_TURN = 3'b010,
    ST_WR_PULS = 3'b011,
    ST_WR_HOLD = 3'b100,
    ST_REST    = 3'b101,
    ST_RETAIN  = 3'b110,
    ST_WAKE    = 3'b111
  } ecsr_state_e;

  // user request
  typedef struct packed {
    logic                  write;                // 1 write, 0 read
    logic [ADDR_W-1:0]     addr;                 // word address
    logic [DATA_W-1:0]     wdata;                // write data
    logic [LANES-1:0]      lane_n;               // lane selects, bit0 low lane, active low
  } ecsr_req_s;

  // control pins toward the memory, all active low
  typedef struct packed {
    logic                  chip_sel_n;           // chip select
    logic                  write_en_n;           // write strobe
    logic                  out_en_n;             // output enable
    logic                  high_byte_sel_n;      // lane for data_lines 15..8
    logic                  low_byte_sel_n;       // lane for data_lines 7..0
  } ecsr_ctl_s;

  localparam ecsr_ctl_s CTL_IDLE = 5'h1f;        // everything deasserted

endpackage

// >>> design/ecsr_timer.sv
// down counter that times one controller phase
`timescale 1ns/1ps
module ecsr_timer (
  input  wire logic                     i_sys_clk, // system clock
  input  wire logic                     i_rst,     // synchronous reset, high
  input  wire logic                     i_load,    // start a new phase
  input  wire logic [ecsr_pkg::CNT_W-1:0] i_len,   // phase length minus one
  output logic                          o_done     // last cycle of the phase
);
  import ecsr_pkg::*;

  logic [CNT_W-1:0] cnt;                         // cycles left in the phase

  // reload on phase entry, otherwise count down and rest at zero
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt <= '0;
    end else if (i_load) begin
      cnt <= i_len;
    end else if (cnt != '0) begin
      cnt <= cnt - 4'h1;
    end
  end

  assign o_done = (cnt == '0);                   // zero marks the final cycle

endmodule // ecsr_timer

// >>> design/ecsr_host.sv
// host controller driving a 64k x 16 asynchronous static memory
`timescale 1ns/1ps
module ecsr_host (
  input  wire logic                          i_sys_clk,         // system clock, 200 MHz
  input  wire logic                          i_rst,             // synchronous reset, high
  input  wire logic                          i_req_valid,       // request offered
  input  wire ecsr_pkg::ecsr_req_s           i_req,             // request contents
  output logic                               o_req_ready,       // request taken when high
  output logic                               o_rsp_valid,       // one-cycle completion pulse
  output logic [ecsr_pkg::DATA_W-1:0]        o_rsp_rdata,       // read data, held
  input  wire logic                          i_retain_req,      // hold memory in retention
  output logic                               o_retained,        // memory deselected for retention
  output logic [ecsr_pkg::ADDR_W-1:0]        o_word_addr_lines, // word address pins
  output ecsr_pkg::ecsr_ctl_s                o_ctl,             // control pins, active low
  input  wire logic [ecsr_pkg::DATA_W-1:0]   i_data_lines,      // data pins as read
  output logic [ecsr_pkg::DATA_W-1:0]        o_data_lines,      // data pins as driven
  output logic [ecsr_pkg::LANES-1:0]         o_data_lines_oe_n  // per lane, low drives
);
  import ecsr_pkg::*;

  // phase length, minus one, for the state being entered
  function automatic logic [CNT_W-1:0] phase_len(input ecsr_state_e st);
    case (st)
      ST_RD_WAIT: phase_len = CNT_W'(AA_CYC - 1);
      ST_WR_TURN: phase_len = CNT_W'(TURN_CYC - 1);
      ST_WR_PULS: phase_len = CNT_W'(WP_CYC - 1);
      ST_WR_HOLD: phase_len = CNT_W'(HOLD_CYC - 1);
      ST_WAKE:    phase_len = CNT_W'(RC_CYC - 1);
      default:    phase_len = CNT_W'(REST_CYC - 1);
    endcase
  endfunction

  ecsr_state_e       state;                      // current phase
  ecsr_state_e       next_state;                 // phase after this edge
  ecsr_req_s         cur;                        // request being served
  logic              phase_done;                 // timer at last cycle
  logic              take;                       // request accepted this cycle
  logic              rd_end;                     // read phase ends this cycle
  logic              wr_end;                     // write hold ends this cycle
  ecsr_ctl_s         next_ctl;                   // control pins for next phase
  logic              next_drive;                 // host drives data next phase
  logic              sel_on;                     // chip selected next, lanes per request

  assign take   = (state == ST_IDLE) && i_req_valid && o_req_ready;
  assign rd_end = (state == ST_RD_WAIT) && phase_done;
  assign wr_end = (state == ST_WR_HOLD) && phase_done;

  // retention may be entered only from idle, so no access is cut short
  assign o_req_ready = (state == ST_IDLE) && !i_retain_req;

  // next phase; each timed phase leaves only when its timer expires
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (i_retain_req) begin
          next_state = ST_RETAIN;
        end else if (i_req_valid) begin
          next_state = i_req.write ? ST_WR_TURN : ST_RD_WAIT;
        end
      end
      ST_RD_WAIT: begin
        if (phase_done) next_state = ST_REST;
      end
      ST_WR_TURN: begin
        if (phase_done) next_state = ST_WR_PULS;
      end
      ST_WR_PULS: begin
        if (phase_done) next_state = ST_WR_HOLD;
      end
      ST_WR_HOLD: begin
        if (phase_done) next_state = ST_REST;
      end
      ST_REST: begin
        if (phase_done) next_state = ST_IDLE;
      end
      ST_RETAIN: begin
        if (!i_retain_req) next_state = ST_WAKE;
      end
      ST_WAKE: begin
        if (phase_done) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // one timer serves every phase; reloaded on each change of state
  ecsr_timer u_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_load    (next_state != state),
    .i_len     (phase_len(next_state)),
    .o_done    (phase_done)
  );

  // pin levels for the phase about to start; registered below
  assign sel_on = (next_state == ST_RD_WAIT) || (next_state == ST_WR_TURN) ||
                  (next_state == ST_WR_PULS) || (next_state == ST_WR_HOLD);
  always_comb begin
    next_ctl = CTL_IDLE;                         // idle, rest, retention: deselected
    if (sel_on) begin
      next_ctl.chip_sel_n = 1'b0;
      // each lane select follows its own request bit
      next_ctl.low_byte_sel_n  = take ? i_req.lane_n[0] : cur.lane_n[0];
      next_ctl.high_byte_sel_n = take ? i_req.lane_n[1] : cur.lane_n[1];
    end
    // reads alone lower output enable; the write strobe stays high
    next_ctl.out_en_n   = !(next_state == ST_RD_WAIT);
    // strobe falls only after select has been low a turnaround span,
    // so memory outputs are already off when the host drives
    next_ctl.write_en_n = !(next_state == ST_WR_PULS);
  end

  // data stays driven through the strobe and one hold cycle after it
  assign next_drive = (next_state == ST_WR_PULS) || (next_state == ST_WR_HOLD);

  // state, captured request and registered pins
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state             <= ST_IDLE;
      cur               <= '0;
      o_word_addr_lines <= '0;
      o_ctl             <= CTL_IDLE;
      o_data_lines      <= '0;
      o_data_lines_oe_n <= '1;
    end else begin
      state <= next_state;
      o_ctl <= next_ctl;
      if (take) begin
        cur               <= i_req;
        // address settles at the same edge that selects go low
        o_word_addr_lines <= i_req.addr;
        o_data_lines      <= i_req.wdata;
      end
      // unselected lanes are never driven
      o_data_lines_oe_n <= next_drive ? cur.lane_n : 2'h3;
    end
  end

  // completion and read capture; data is sampled at the last cycle of the
  // full access delay
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= '0;
      o_retained  <= 1'b0;
    end else begin
      o_rsp_valid <= rd_end || wr_end;
      if (rd_end) begin
        o_rsp_rdata <= i_data_lines;
      end
      o_retained <= (next_state == ST_RETAIN) || (next_state == ST_WAKE);
    end
  end

  // helper counters for the assertions
  // each one saturates, so a long idle spell never wraps into a false match
  logic [CNT_W-1:0] rd_run;                      // cycles of stable read select
  logic [CNT_W-1:0] oe_off;                      // cycles since output enable high
  logic [CNT_W-1:0] since_wake;                  // cycles since retention released

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rd_run     <= '0;
      oe_off     <= '1;
      since_wake <= '1;
    end else begin
      rd_run <= (!o_ctl.chip_sel_n && !o_ctl.out_en_n && rd_run != '1)
                ? rd_run + 4'h1 : ((o_ctl.out_en_n) ? '0 : rd_run);
      oe_off <= !o_ctl.out_en_n ? '0 : ((oe_off != '1) ? oe_off + 4'h1 : oe_off);
      since_wake <= (state == ST_RETAIN) ? '0
                    : ((since_wake != '1) ? since_wake + 4'h1 : since_wake);
    end
  end

  a_read_strobe_high: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_ctl.out_en_n |-> o_ctl.write_en_n && o_data_lines_oe_n == 2'h3)
    else $error("write strobe or host drive during a read");

  a_read_full_delay: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    rd_end |-> rd_run == CNT_W'(AA_CYC - 1) && !o_ctl.out_en_n)
    else $error("read data taken before the address delay");

  a_read_addr_stable: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_ctl.chip_sel_n && !$past(o_ctl.chip_sel_n) |-> $stable(o_word_addr_lines))
    else $error("address moved while selected");

  a_drive_after_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_data_lines_oe_n != 2'h3 |-> oe_off >= CNT_W'(TURN_CYC) && o_ctl.out_en_n)
    else $error("host drove data before memory outputs turned off");

  a_strobe_after_sel: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_ctl.write_en_n) |-> !$past(o_ctl.chip_sel_n, 3) && !o_ctl.chip_sel_n)
    else $error("write strobe fell without prior select");

  a_wake_recovery: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_ctl.chip_sel_n) && since_wake != '1 |-> since_wake >= CNT_W'(RC_CYC))
    else $error("access started too soon after retention");

  a_lane_gating: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_data_lines_oe_n[0] |-> !o_ctl.low_byte_sel_n && !o_ctl.chip_sel_n)
    else $error("low lane driven without its select");

  a_pulse_width: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_ctl.write_en_n) |-> !o_ctl.write_en_n [*7] ##1 o_ctl.write_en_n)
    else $error("write strobe width wrong");

endmodule // ecsr_host

// >>> verification/ecsr_mem_model.sv
// behavioural 64k x 16 static memory standing on the host controller's pins
`timescale 1ns/1ps
module ecsr_mem_model #(
  parameter int ACC_NS = 40                          // address to data, inside the host window
) (
  input  wire logic [ecsr_pkg::ADDR_W-1:0] i_addr,   // word address pins
  input  wire ecsr_pkg::ecsr_ctl_s         i_ctl,    // control pins, active low
  input  wire logic [ecsr_pkg::DATA_W-1:0] i_hdata,  // host drive value
  input  wire logic [ecsr_pkg::LANES-1:0]  i_hoe_n,  // host lane drive, low drives
  output wire logic [ecsr_pkg::DATA_W-1:0] o_bus     // resolved data lines
);
  import ecsr_pkg::*;
  logic [DATA_W-1:0] mem [0:65535];                  // one word per address
  logic [DATA_W-1:0] rd_late;                        // word after the access delay
  logic [DATA_W-1:0] float_v = 16'h0000;             // level of released lanes
  logic [LANES-1:0]  mem_drv;                        // lanes the memory drives
  // drive only when selected, output enabled, strobe high; lanes apart
  assign mem_drv = (i_ctl.chip_sel_n || !i_ctl.write_en_n || i_ctl.out_en_n) ? 2'b00
                   : ~{i_ctl.high_byte_sel_n, i_ctl.low_byte_sel_n};
  // the stored word reaches rd_late ACC_NS after the address changes
  assign #(ACC_NS) rd_late = mem[i_addr];
  // per lane the driving party wins; an idle lane must not keep its last level
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign o_bus[8*l+:8] = !i_hoe_n[l] ? i_hdata[8*l+:8]
                         : mem_drv[l] ? rd_late[8*l+:8] : float_v[8*l+:8];
  end
  // released lines show the inverse, so a stale sample cannot pass
  always @(i_hoe_n or mem_drv) begin
    float_v = ~o_bus;
  end
  // store at the strobe rise while selected, chosen lanes only
  always @(posedge i_ctl.write_en_n) begin
    if (!i_ctl.chip_sel_n && !i_ctl.low_byte_sel_n) mem[i_addr][7:0] = o_bus[7:0];
    if (!i_ctl.chip_sel_n && !i_ctl.high_byte_sel_n) mem[i_addr][15:8] = o_bus[15:8];
  end
endmodule // ecsr_mem_model

// >>> verification/test_ecsr_host.sv
// self-checking bench for the memory host controller
`timescale 1ns/1ps
`define chk_eq(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_ecsr_host;
  import ecsr_pkg::*;
  typedef struct packed {
    logic        wr;                                 // 1 write
    logic [15:0] addr;                               // word address
    logic [15:0] wd;                                 // write data
    logic [1:0]  ln;                                 // lane selects, low active
    logic [15:0] exp;                                // expected read word
    logic [15:0] msk;                                // lanes that are compared
  } ecsr_row_s;
  logic              sys_clk, rst, req_valid, retain, prev_cs_n;
  ecsr_req_s         req;                            // request contents
  logic              o_req_ready, o_rsp_valid, o_retained;
  logic [15:0]       o_rsp_rdata, o_word_addr_lines, o_data_lines, bus, prev_addr;
  ecsr_ctl_s         o_ctl;                          // control pins
  logic [1:0]        o_data_lines_oe_n;              // host lane drive
  int                fail_count = 0, compares = 0, k;
  ecsr_row_s         rows [9] = '{
    '{1'b1, 16'h0000, 16'h1234, 2'b00, 16'h0000, 16'h0000},
    '{1'b1, 16'hffff, 16'habcd, 2'b00, 16'h0000, 16'h0000},
    '{1'b0, 16'h0000, 16'h0000, 2'b00, 16'h1234, 16'hffff},
    '{1'b0, 16'hffff, 16'h0000, 2'b00, 16'habcd, 16'hffff},
    '{1'b1, 16'h0000, 16'h5566, 2'b10, 16'h0000, 16'h0000},
    '{1'b0, 16'h0000, 16'h0000, 2'b00, 16'h1266, 16'hffff},
    '{1'b1, 16'hffff, 16'h7788, 2'b01, 16'h0000, 16'h0000},
    '{1'b0, 16'hffff, 16'h0000, 2'b10, 16'h00cd, 16'h00ff},
    '{1'b0, 16'hffff, 16'h0000, 2'b01, 16'h7700, 16'hff00}};
  ecsr_host uut (.i_sys_clk(sys_clk), .i_rst(rst), .i_req_valid(req_valid), .i_req(req),
    .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
    .i_retain_req(retain), .o_retained(o_retained), .o_word_addr_lines(o_word_addr_lines),
    .o_ctl(o_ctl), .i_data_lines(bus), .o_data_lines(o_data_lines),
    .o_data_lines_oe_n(o_data_lines_oe_n));
  ecsr_mem_model mem (.i_addr(o_word_addr_lines), .i_ctl(o_ctl), .i_hdata(o_data_lines),
    .i_hoe_n(o_data_lines_oe_n), .o_bus(bus));
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // pins watched every cycle: no strobe or host drive during a read window, address steady while selected
  always @(negedge sys_clk) begin
    if (!rst && !o_ctl.out_en_n) `chk_eq({o_ctl.write_en_n, o_data_lines_oe_n}, 3'b111)
    if (!rst && !o_ctl.chip_sel_n && !prev_cs_n) `chk_eq(o_word_addr_lines, prev_addr)
    prev_cs_n = o_ctl.chip_sel_n;
    prev_addr = o_word_addr_lines;
  end
  // offer one request, then count cycles from the take edge to the pulse
  task automatic run_row(input ecsr_row_s r);
    int n;
    n = 0;
    @(negedge sys_clk);
    req_valid = 1'b1;
    req = '{r.wr, r.addr, r.wd, r.ln};
    while (o_req_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 1;
    while (o_rsp_valid !== 1'b1 && n < 30) begin
      @(negedge sys_clk);
      n++;
    end
    `chk_eq(n, r.wr ? 12 : 10)
    if (!r.wr) `chk_eq(o_rsp_rdata & r.msk, r.exp & r.msk)
    $display("row done wr %b addr %h", r.wr, r.addr);
  endtask
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // cut a hang short well past the expected run
  initial begin
    #(20000 * CLK_NS);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    retain = 1'b0;
    req = '0;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    `chk_eq({o_ctl, o_data_lines_oe_n, o_rsp_valid, o_retained}, {CTL_IDLE, 4'hc})
    foreach (rows[i]) run_row(rows[i]);
    // reset in the turnaround phase: pins idle, strobe never fell, no store
    @(negedge sys_clk);
    req_valid = 1'b1;
    req = '{1'b1, 16'h0000, 16'hffff, 2'b00};
    @(negedge sys_clk);
    req_valid = 1'b0;
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    `chk_eq({o_ctl, o_data_lines_oe_n}, {CTL_IDLE, 2'b11})
    run_row(rows[5]);
    $display("mid-write reset done");
    // retention: memory held deselected, then a full read period before use
    @(negedge sys_clk);
    retain = 1'b1;
    repeat (4) @(negedge sys_clk);
    `chk_eq({o_retained, o_ctl, o_req_ready}, {1'b1, CTL_IDLE, 1'b0})
    retain = 1'b0;
    k = 0;
    while (o_req_ready !== 1'b1 && k < 50) begin
      @(negedge sys_clk);
      k++;
    end
    `chk_eq(k >= RC_CYC, 1'b1)
    run_row(rows[5]);
    $display("retention done");
    test_done();
  end
endmodule // test_ecsr_host
